// >>> off_seq_params.svh
// offsets, reset values, field positions and timing constants of the output off sequencer
`ifndef OFF_SEQ_PARAMS_SVH
`define OFF_SEQ_PARAMS_SVH

// command codes of the setting registers
`define CMD_OUT_OV_ACT 8'h41
`define CMD_OUT_UV_ACT 8'h45
`define CMD_IN_OV_ACT 8'h56
`define CMD_TON_ACT 8'h63
`define CMD_OFF_WAIT 8'h64
`define CMD_OFF_RAMP 8'h65
`define CMD_OFF_WARN 8'h66
`define CMD_RETRY 8'hdb
`define CMD_HOLD 8'hdc

// reset values of the setting registers
`define RST_OUT_OV_ACT 8'hb8
`define RST_OUT_UV_ACT 8'hb8
`define RST_IN_OV_ACT 8'h80
`define RST_TON_ACT 8'hb8
`define RST_OFF_WAIT 16'h8000
`define RST_OFF_RAMP 16'hd200
`define RST_OFF_WARN 16'hf258
`define RST_RETRY 16'hfabc
`define RST_HOLD 16'hfbe8

// fields of the two-byte linear format
`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MANT_MSB 10

// fields of the fault action byte
`define ACT_SHUT_MSB 7
`define ACT_SHUT_LSB 6
`define ACT_RETRY_MSB 5
`define ACT_RETRY_LSB 3

// channel configuration bit that drops the decay wait
`define CFG_DECAY_SKIP_BIT 0

// time base: one tick every 10 us at 250 MHz
`define TICK_TIME_US 10
`define MCLK_MHZ 250
`define TICK_CYCLES (`TICK_TIME_US * `MCLK_MHZ)

// limits of the timed settings, in their printed units
`define OFF_WAIT_MAX_MS 83000
`define RAMP_MIN_US 250
`define RAMP_MAX_MS 1300
`define RAMP_STEP_US 100
`define WARN_MIN_MS 120
`define WARN_MAX_MS 524000
`define HOLD_MIN_MS 136
`define HOLD_MAX_MS 65520
`define HOLD_RES_MS 16
`define RETRY_MIN_MS 120
`define RETRY_MAX_MS 83880

`endif

// >>> off_seq_pkg.sv
// types and value conversion helpers of the output off sequencer
`include "off_seq_params.svh"
package off_seq_pkg;

  // sequencer phases
  typedef enum logic [2:0] {ST_OFF, ST_ON, ST_OFF_DELAY, ST_FALL, ST_DECAY, ST_RETRY} seq_state_type;

  // complete state of the sequencer
  typedef struct packed {
    seq_state_type state;
    logic [7:0] act_out_ov;
    logic [7:0] act_out_uv;
    logic [7:0] act_in_ov;
    logic [7:0] act_ton;
    logic [15:0] t_off_wait;
    logic [15:0] t_off_ramp;
    logic [15:0] t_off_warn;
    logic [15:0] t_retry;
    logic [15:0] t_hold;
    logic [31:0] timer;
    logic [31:0] warn_cnt;
    logic [31:0] err;
    logic [11:0] level;
    logic [11:0] dac;
    logic [3:0] step_cnt;
    logic holding;
    logic [31:0] hold_sub;
    logic [31:0] hold_gran;
    logic run_prev;
    logic fault_off;
    logic gate_hiz;
    logic sink_en;
    logic start_pulse;
    logic toff_warn;
    logic sb_nota;
    logic sw_input;
    logic si_in_ov;
    logic [15:0] rd_data;
    logic unmapped;
  } off_seq_state_type;

  // linear value in ms to 10 us ticks, negative reads as zero, saturating
  function automatic logic [31:0] l11_to_ticks(input logic [15:0] v);
    logic [47:0] p;
    p = '0;
    if (!v[`L11_MANT_MSB]) begin
      p = {37'h0_0000_0000, v[`L11_MANT_MSB:0]} * 48'(1000 / `TICK_TIME_US);
    end
    if (!v[`L11_EXP_MSB]) begin
      p = p << v[`L11_EXP_MSB:`L11_EXP_LSB];
    end else begin
      p = p >> (5'h00 - v[`L11_EXP_MSB:`L11_EXP_LSB]);
    end
    return (|p[47:32]) ? 32'hffff_ffff : p[31:0];
  endfunction : l11_to_ticks

  // bound a tick count to a legal window
  function automatic logic [31:0] clamp_ticks(input logic [31:0] x, input logic [31:0] lo, input logic [31:0] hi);
    if (x < lo) begin
      return lo;
    end else if (x > hi) begin
      return hi;
    end
    return x;
  endfunction : clamp_ticks

endpackage : off_seq_pkg

// >>> sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // level in and synchronised level out
  input wire logic d_i,
  output logic q_o
);

  logic meta; // first stage, read only by the second

  // both stages clear under reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : sync2
`default_nettype wire

// >>> tick_gen.sv
// divider making a one-cycle time base enable pulse
`timescale 1ns/100ps
`default_nettype none
`include "off_seq_params.svh"
module tick_gen #(
  parameter int DIV = `TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // one-cycle pulse every DIV cycles
  output logic tick_o
);

  localparam int CW = $clog2(DIV);

  // a single-cycle period would make the enable a constant level
  if (DIV < 2) begin : g_bad_div
    $error("tick_gen: DIV must be at least 2");
  end

  logic [CW-1:0] cnt; // cycles into the current period

  // wrap at DIV-1 and pulse on the wrap
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt <= cnt + CW'(1);
      tick_o <= 1'b0;
    end
  end

endmodule : tick_gen
`default_nettype wire

// >>> output_off_sequencer.sv
// off sequence, enable pin hold, fault retry and fault action settings of one output channel
//
// Overview of operation
// R1 - off request waits programmed delay, up to 83 s
// R2 - faults are ignored during the off delay
// R3 - ramp reference to zero, then float gates
// R4 - ramp lasts at least 0.25 ms, at most 1.3 s
// R5 - ramp moves in 0.1 ms steps
// R6 - conduction mode kept during the ramp
// R7 - discontinuous mode never sinks load current during the ramp
// R8 - warn if output stays above 12.5 percent
// R9 - zero warn limit disables; else 120 ms-524 s
// R10 - pin falling edge: hold pin low, restart
// R11 - hold time 136 ms-65.52 s, 16 ms steps
// R12 - host programs hold above delay plus fall
// R13 - decay check keeps output off until decayed
// R14 - one retry interval, timed from fault detection
// R15 - retry interval 120 ms-83.88 s, 10 us steps
// R16 - retry waits longer of interval and decay
// R17 - input overvoltage sets status bits and alert
// R18 - four writable fault action bytes with defaults
// R19 - timed settings are two-byte linear values
// R20 - linear value: 11-bit mantissa, 5-bit exponent
`timescale 1ns/100ps
`default_nettype none
`include "off_seq_params.svh"
module output_off_sequencer #(
  parameter int TICK_DIV = `TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // open-drain enable pin
  input wire logic enable_pin_i,
  output logic enable_pin_o,
  output logic enable_pin_oe_o,
  // channel control from the surrounding logic
  input wire logic op_on_i,
  input wire logic ccm_mode_i,
  input wire logic [11:0] vout_code_i,
  input wire logic [7:0] channel_config_word_i,
  // output below 12.5 percent comparator, asynchronous
  input wire logic vout_below_eighth_i,
  // fault detections, one-cycle pulses
  input wire logic in_ov_fault_i,
  input wire logic out_ov_fault_i,
  input wire logic out_uv_fault_i,
  input wire logic ton_max_fault_i,
  input wire logic clear_faults_i,
  // command port
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  output logic [15:0] cmd_rd_data_o,
  output logic cmd_unmapped_o,
  // power stage side
  output logic [11:0] dac_ref_o,
  output logic gate_hiz_o,
  output logic sink_enable_o,
  output logic channel_on_o,
  output logic start_pulse_o,
  // status
  output logic toff_warn_o,
  output logic status_byte_nota_o,
  output logic status_word_input_o,
  output logic status_input_in_ov_o,
  output logic alert_o
);

  localparam logic [31:0] TPM = 32'(1000 / `TICK_TIME_US); // ticks per ms

  // state after reset: channel off, gates floating, settings at defaults
  localparam off_seq_pkg::off_seq_state_type RESET_VALUE = '{
    state: off_seq_pkg::ST_OFF,
    act_out_ov: `RST_OUT_OV_ACT,
    act_out_uv: `RST_OUT_UV_ACT,
    act_in_ov: `RST_IN_OV_ACT,
    act_ton: `RST_TON_ACT,
    t_off_wait: `RST_OFF_WAIT,
    t_off_ramp: `RST_OFF_RAMP,
    t_off_warn: `RST_OFF_WARN,
    t_retry: `RST_RETRY,
    t_hold: `RST_HOLD,
    gate_hiz: 1'b1,
    default: '0
  };

  logic rst_n_sync; // reset released in step with the clock
  logic run_s; // synchronised enable pin level
  logic below_s; // synchronised decay comparator
  logic tick; // 10 us time base enable

  off_seq_pkg::off_seq_state_type cur; // registered state
  off_seq_pkg::off_seq_state_type next_cur; // next state

  // decoded settings, in ticks, clock cycles or 16 ms hold granules
  logic [31:0] off_ticks;
  logic [31:0] ramp_ticks;
  logic [31:0] ramp_cycles;
  logic [31:0] warn_ticks;
  logic warn_on;
  logic [31:0] retry_ticks;
  logic [31:0] hold_grans;
  logic [31:0] warn_raw;

  // request and fault summaries
  logic on_req;
  logic decay_skip;
  logic [3:0] fault_vec;
  logic [3:0] shut_vec;
  logic [3:0] retry_vec;
  logic fault_shut;
  logic fault_retry;

  // reset release: assertion is immediate, release waits two edges
  sync2 u_rst_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .d_i(1'b1),
    .q_o(rst_n_sync)
  );

  // the pin may be driven by anyone on the board
  sync2 u_run_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_sync),
    .d_i(enable_pin_i),
    .q_o(run_s)
  );

  // analog comparator, not tied to this clock
  sync2 u_below_sync (
    .clk_i(mclk_i),
    .rst_n_i(rst_n_sync),
    .d_i(vout_below_eighth_i),
    .q_o(below_s)
  );

  // all timers advance on this enable
  tick_gen #(
    .DIV(TICK_DIV)
  ) u_tick (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_sync),
    .tick_o(tick)
  );

  // settings decoded from the linear format into tick counts
  always_comb begin
    off_ticks = off_seq_pkg::clamp_ticks(off_seq_pkg::l11_to_ticks(cur.t_off_wait), 32'h0000_0000,
      32'(`OFF_WAIT_MAX_MS) * TPM); // [R1] [R19] [R20]
    // short ramps are stretched rather than skipped, so the stage never slams off
    ramp_ticks = off_seq_pkg::clamp_ticks(off_seq_pkg::l11_to_ticks(cur.t_off_ramp),
      32'(`RAMP_MIN_US / `TICK_TIME_US), 32'(`RAMP_MAX_MS) * TPM); // [R4]
    ramp_cycles = 32'(ramp_ticks * 32'(TICK_DIV));
    warn_raw = off_seq_pkg::l11_to_ticks(cur.t_off_warn);
    warn_on = (warn_raw != 32'h0000_0000); // [R9]
    warn_ticks = off_seq_pkg::clamp_ticks(warn_raw, 32'(`WARN_MIN_MS) * TPM, 32'(`WARN_MAX_MS) * TPM); // [R9]
    retry_ticks = off_seq_pkg::clamp_ticks(off_seq_pkg::l11_to_ticks(cur.t_retry),
      32'(`RETRY_MIN_MS) * TPM, 32'(`RETRY_MAX_MS) * TPM); // [R15]
    // hold counts whole 16 ms granules, rounding up
    hold_grans = (off_seq_pkg::clamp_ticks(off_seq_pkg::l11_to_ticks(cur.t_hold),
      32'(`HOLD_MIN_MS) * TPM, 32'(`HOLD_MAX_MS) * TPM) + 32'(`HOLD_RES_MS) * TPM - 32'h0000_0001)
      / (32'(`HOLD_RES_MS) * TPM); // [R11]
  end

  // requests and the fault action lookup
  always_comb begin
    on_req = run_s & op_on_i;
    decay_skip = channel_config_word_i[`CFG_DECAY_SKIP_BIT];
    fault_vec = {ton_max_fault_i, out_uv_fault_i, out_ov_fault_i, in_ov_fault_i};
    // action fields: nonzero response shuts down, nonzero retry field retries
    shut_vec[0] = fault_vec[0] & (|cur.act_in_ov[`ACT_SHUT_MSB:`ACT_SHUT_LSB]);
    shut_vec[1] = fault_vec[1] & (|cur.act_out_ov[`ACT_SHUT_MSB:`ACT_SHUT_LSB]);
    shut_vec[2] = fault_vec[2] & (|cur.act_out_uv[`ACT_SHUT_MSB:`ACT_SHUT_LSB]);
    shut_vec[3] = fault_vec[3] & (|cur.act_ton[`ACT_SHUT_MSB:`ACT_SHUT_LSB]);
    retry_vec[0] = shut_vec[0] & (|cur.act_in_ov[`ACT_RETRY_MSB:`ACT_RETRY_LSB]);
    retry_vec[1] = shut_vec[1] & (|cur.act_out_ov[`ACT_RETRY_MSB:`ACT_RETRY_LSB]);
    retry_vec[2] = shut_vec[2] & (|cur.act_out_uv[`ACT_RETRY_MSB:`ACT_RETRY_LSB]);
    retry_vec[3] = shut_vec[3] & (|cur.act_ton[`ACT_RETRY_MSB:`ACT_RETRY_LSB]);
    fault_shut = |shut_vec;
    fault_retry = |retry_vec;
  end

  // next state of the whole block
  always_comb begin
    next_cur = cur;
    next_cur.start_pulse = 1'b0;
    next_cur.unmapped = 1'b0;
    next_cur.run_prev = run_s;

    // command writes; byte settings take the low byte
    if (cmd_wr_i) begin
      case (cmd_code_i)
        `CMD_OUT_OV_ACT: next_cur.act_out_ov = cmd_data_i[7:0]; // [R18]
        `CMD_OUT_UV_ACT: next_cur.act_out_uv = cmd_data_i[7:0]; // [R18]
        `CMD_IN_OV_ACT: next_cur.act_in_ov = cmd_data_i[7:0]; // [R18]
        `CMD_TON_ACT: next_cur.act_ton = cmd_data_i[7:0]; // [R18]
        `CMD_OFF_WAIT: next_cur.t_off_wait = cmd_data_i; // [R19]
        `CMD_OFF_RAMP: next_cur.t_off_ramp = cmd_data_i; // [R19]
        `CMD_OFF_WARN: next_cur.t_off_warn = cmd_data_i; // [R19]
        `CMD_RETRY: next_cur.t_retry = cmd_data_i; // [R19]
        `CMD_HOLD: next_cur.t_hold = cmd_data_i; // [R19]
        default: next_cur.unmapped = 1'b1; // unknown code, write dropped
      endcase
    end

    // command reads, answered on the next edge
    if (cmd_rd_i) begin
      case (cmd_code_i)
        `CMD_OUT_OV_ACT: next_cur.rd_data = {8'h00, cur.act_out_ov};
        `CMD_OUT_UV_ACT: next_cur.rd_data = {8'h00, cur.act_out_uv};
        `CMD_IN_OV_ACT: next_cur.rd_data = {8'h00, cur.act_in_ov};
        `CMD_TON_ACT: next_cur.rd_data = {8'h00, cur.act_ton};
        `CMD_OFF_WAIT: next_cur.rd_data = cur.t_off_wait;
        `CMD_OFF_RAMP: next_cur.rd_data = cur.t_off_ramp;
        `CMD_OFF_WARN: next_cur.rd_data = cur.t_off_warn;
        `CMD_RETRY: next_cur.rd_data = cur.t_retry;
        `CMD_HOLD: next_cur.rd_data = cur.t_hold;
        default: begin
          next_cur.rd_data = 16'h0000;
          next_cur.unmapped = 1'b1;
        end
      endcase
    end

    // status flags: a new fault beats a clear in the same cycle
    if (clear_faults_i) begin
      next_cur.sb_nota = 1'b0;
      next_cur.sw_input = 1'b0;
      next_cur.si_in_ov = 1'b0;
      next_cur.toff_warn = 1'b0;
    end
    if (in_ov_fault_i) begin
      next_cur.sb_nota = 1'b1; // [R17]
      next_cur.sw_input = 1'b1; // [R17]
      next_cur.si_in_ov = 1'b1; // [R17]
    end

    // pin hold: our own drive cannot make a second falling edge
    if (cur.run_prev && !run_s && !cur.holding) begin
      next_cur.holding = 1'b1; // [R10]
      next_cur.hold_sub = 32'h0000_0000;
      next_cur.hold_gran = 32'h0000_0000;
    end else if (cur.holding && tick) begin
      if (cur.hold_sub == 32'(`HOLD_RES_MS) * TPM - 32'h0000_0001) begin
        next_cur.hold_sub = 32'h0000_0000;
        next_cur.hold_gran = cur.hold_gran + 32'h0000_0001;
        if (cur.hold_gran + 32'h0000_0001 >= hold_grans) begin
          next_cur.holding = 1'b0; // [R11]
        end
      end else begin
        next_cur.hold_sub = cur.hold_sub + 32'h0000_0001;
      end
    end

    // sequencer
    case (cur.state)
      off_seq_pkg::ST_OFF: begin
        next_cur.gate_hiz = 1'b1;
        next_cur.sink_en = 1'b0;
        next_cur.dac = 12'h000;
        // a latched-off fault needs an off request before a new start
        if (!on_req) begin
          next_cur.fault_off = 1'b0;
        end else if (!cur.holding && !cur.fault_off && (decay_skip || below_s)) begin
          next_cur.state = off_seq_pkg::ST_ON; // [R10] [R13]
          next_cur.start_pulse = 1'b1;
          next_cur.gate_hiz = 1'b0;
          next_cur.sink_en = 1'b1;
          next_cur.dac = vout_code_i;
        end
      end
      off_seq_pkg::ST_ON: begin
        next_cur.dac = vout_code_i;
        next_cur.level = vout_code_i;
        next_cur.timer = 32'h0000_0000;
        if (fault_shut) begin
          next_cur.gate_hiz = 1'b1;
          next_cur.sink_en = 1'b0;
          next_cur.dac = 12'h000;
          next_cur.level = 12'h000;
          next_cur.fault_off = !fault_retry;
          next_cur.state = fault_retry ? off_seq_pkg::ST_RETRY : off_seq_pkg::ST_OFF; // [R14]
        end else if (!on_req) begin
          next_cur.state = off_seq_pkg::ST_OFF_DELAY; // [R1]
        end
      end
      off_seq_pkg::ST_OFF_DELAY: begin
        // fault inputs are not looked at here
        if (on_req) begin
          next_cur.state = off_seq_pkg::ST_ON; // [R2]
        end else if (cur.timer >= off_ticks) begin
          next_cur.state = off_seq_pkg::ST_FALL; // [R1]
          next_cur.timer = 32'h0000_0000;
          next_cur.err = 32'h0000_0000;
          next_cur.step_cnt = 4'h0;
          next_cur.sink_en = ccm_mode_i; // [R6] [R7]
        end else if (tick) begin
          next_cur.timer = cur.timer + 32'h0000_0001;
        end
      end
      off_seq_pkg::ST_FALL: begin
        // sinking only in continuous mode; pulse skipping lets the load pull it down
        next_cur.sink_en = ccm_mode_i; // [R6] [R7]
        // spread vout_code decrements evenly over the ramp cycles
        if (cur.err + 32'(vout_code_i) >= ramp_cycles) begin
          next_cur.err = cur.err + 32'(vout_code_i) - ramp_cycles;
          if (cur.level != 12'h000) begin
            next_cur.level = cur.level - 12'h001;
          end
        end else begin
          next_cur.err = cur.err + 32'(vout_code_i);
        end
        if (fault_shut) begin
          next_cur.gate_hiz = 1'b1;
          next_cur.sink_en = 1'b0;
          next_cur.dac = 12'h000;
          next_cur.level = 12'h000;
          next_cur.timer = 32'h0000_0000;
          next_cur.fault_off = !fault_retry;
          next_cur.state = fault_retry ? off_seq_pkg::ST_RETRY : off_seq_pkg::ST_OFF; // [R14]
        end else if (tick) begin
          next_cur.timer = cur.timer + 32'h0000_0001;
          // the reference moves at 0.1 ms step boundaries and drops to zero when the ramp time is up
          if (cur.step_cnt == 4'(`RAMP_STEP_US / `TICK_TIME_US - 1)) begin
            next_cur.step_cnt = 4'h0;
            next_cur.dac = cur.level; // [R5]
          end else begin
            next_cur.step_cnt = cur.step_cnt + 4'h1;
          end
          if (cur.timer + 32'h0000_0001 >= ramp_ticks) begin
            next_cur.dac = 12'h000; // [R3]
            next_cur.level = 12'h000;
            next_cur.gate_hiz = 1'b1; // [R3]
            next_cur.sink_en = 1'b0;
            next_cur.warn_cnt = 32'h0000_0000;
            next_cur.state = off_seq_pkg::ST_DECAY;
          end
        end
      end
      off_seq_pkg::ST_DECAY: begin
        // time the natural decay; without the decay check there is nothing to wait for
        if (decay_skip || below_s) begin
          next_cur.state = off_seq_pkg::ST_OFF;
        end else if (tick) begin
          next_cur.warn_cnt = cur.warn_cnt + 32'h0000_0001;
          if (warn_on && (cur.warn_cnt + 32'h0000_0001 == warn_ticks)) begin
            next_cur.toff_warn = 1'b1; // [R8] [R9]
          end
        end
      end
      off_seq_pkg::ST_RETRY: begin
        next_cur.gate_hiz = 1'b1;
        next_cur.dac = 12'h000;
        if (!on_req) begin
          next_cur.state = off_seq_pkg::ST_OFF;
        end else if ((cur.timer >= retry_ticks) && (decay_skip || below_s)) begin
          next_cur.state = off_seq_pkg::ST_ON; // [R16]
          next_cur.start_pulse = 1'b1;
          next_cur.gate_hiz = 1'b0;
          next_cur.sink_en = 1'b1;
          next_cur.dac = vout_code_i;
        end else if (tick && (cur.timer < retry_ticks)) begin
          next_cur.timer = cur.timer + 32'h0000_0001; // [R14]
        end
      end
      default: begin
        next_cur.state = off_seq_pkg::ST_OFF;
      end
    endcase

    // the warning may also be set in the same cycle as a clear
    if (clear_faults_i && !(cur.state == off_seq_pkg::ST_DECAY && next_cur.toff_warn && !cur.toff_warn)) begin
      next_cur.toff_warn = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge mclk_i or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      cur <= RESET_VALUE;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from the state register
  assign enable_pin_o = 1'b0; // open drain: only ever pulls low
  assign enable_pin_oe_o = cur.holding; // [R10]
  assign cmd_rd_data_o = cur.rd_data;
  assign cmd_unmapped_o = cur.unmapped;
  assign dac_ref_o = cur.dac;
  assign gate_hiz_o = cur.gate_hiz;
  assign sink_enable_o = cur.sink_en;
  assign channel_on_o = (cur.state != off_seq_pkg::ST_OFF) && (cur.state != off_seq_pkg::ST_RETRY)
    && (cur.state != off_seq_pkg::ST_DECAY);
  assign start_pulse_o = cur.start_pulse;
  assign toff_warn_o = cur.toff_warn;
  assign status_byte_nota_o = cur.sb_nota;
  assign status_word_input_o = cur.sw_input;
  assign status_input_in_ov_o = cur.si_in_ov;
  assign alert_o = cur.sb_nota | cur.toff_warn; // [R17]

endmodule : output_off_sequencer
`default_nettype wire

// >>> oos_props.sv
// concurrent checks on the output off sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "off_seq_params.svh"
module oos_props (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // inputs watched
  input wire logic in_ov_fault_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [15:0] cmd_data_i,
  // outputs watched
  input wire logic [15:0] cmd_rd_data_o,
  input wire logic cmd_unmapped_o,
  input wire logic [11:0] dac_ref_o,
  input wire logic gate_hiz_o,
  input wire logic enable_pin_o,
  input wire logic enable_pin_oe_o,
  input wire logic status_byte_nota_o,
  input wire logic status_word_input_o,
  input wire logic status_input_in_ov_o,
  input wire logic alert_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // word codes, all known codes
  wire logic wd = cmd_code_i inside {`CMD_OFF_WAIT, `CMD_OFF_RAMP, `CMD_OFF_WARN, `CMD_RETRY, `CMD_HOLD};
  wire logic kn = wd || cmd_code_i inside {`CMD_OUT_OV_ACT, `CMD_OUT_UV_ACT, `CMD_IN_OV_ACT, `CMD_TON_ACT};
  wire logic acc = cmd_wr_i || cmd_rd_i;
  sequence s_wr;
    cmd_wr_i && wd;
  endsequence
  // matching read two edges on, no write between
  sequence s_rd;
    cmd_rd_i && !cmd_wr_i && !$past(cmd_wr_i) && cmd_code_i == $past(cmd_code_i, 2);
  endsequence
  AST_IN_OV_FLAGS: assert property (in_ov_fault_i |=>
    status_byte_nota_o && status_word_input_o && status_input_in_ov_o && alert_o) else $error("in ov flags");
  AST_HIZ_AT_ZERO: assert property ($rose(gate_hiz_o) |-> dac_ref_o == 12'h000) else $error("float early");
  AST_UNKNOWN_FLAG: assert property (acc && !kn |=> cmd_unmapped_o) else $error("no unmapped flag");
  AST_KNOWN_QUIET: assert property (acc && kn |=> !cmd_unmapped_o) else $error("false flag");
  AST_UNKNOWN_ZERO: assert property (cmd_rd_i && !kn |=> cmd_rd_data_o == 16'h0000) else $error("bad read");
  AST_WORD_BACK: assert property (s_wr ##2 s_rd |=> cmd_rd_data_o == $past(cmd_data_i, 3)) else $error("readback");
  AST_PIN_LOW: assert property (enable_pin_oe_o |-> !enable_pin_o) else $error("pin driven high");
  AST_HOLD_MIN: assert property ($rose(enable_pin_oe_o) |-> enable_pin_oe_o [*8]) else $error("hold short");
endmodule : oos_props
bind output_off_sequencer oos_props u_oos_props (.*);
`default_nettype wire

// >>> oos_host.sv
// host model: command strobes and the pulled-up enable pin
`timescale 1ns/100ps
`default_nettype none
module oos_host (
  // clock
  input wire logic mclk_i,
  // enable pin
  input wire logic enable_pin_oe_i,
  input wire logic ext_low_i,
  output logic enable_pin_o,
  // command port
  input wire logic [15:0] cmd_rd_data_i,
  input wire logic cmd_unmapped_i,
  output logic cmd_wr_o = 1'b0,
  output logic cmd_rd_o = 1'b0,
  output logic [7:0] cmd_code_o = 8'h00,
  output logic [15:0] cmd_data_o = 16'h0000
);
  // pull-up wins unless a party pulls low
  assign enable_pin_o = !(enable_pin_oe_i || ext_low_i);
  // one strobe, whole word; released lines show junk
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(posedge mclk_i) #1;
    {cmd_wr_o, cmd_code_o, cmd_data_o} = {1'b1, c, d};
    @(posedge mclk_i) #1;
    {cmd_wr_o, cmd_code_o, cmd_data_o} = {1'b0, ~c, ~d};
  endtask : wr
  // answer taken one edge after the strobe
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic u);
    @(posedge mclk_i) #1;
    {cmd_rd_o, cmd_code_o} = {1'b1, c};
    @(posedge mclk_i) #1;
    {cmd_rd_o, cmd_code_o} = {1'b0, ~c};
    d = cmd_rd_data_i;
    u = cmd_unmapped_i;
  endtask : rd
endmodule : oos_host
`default_nettype wire

// >>> output_off_sequencer_tb.sv
// self-checking bench of the output off sequencer
`timescale 1ns/100ps
`default_nettype none
module output_off_sequencer_tb;
  localparam int DIV = 2; // two-cycle tick
  logic cfg = 1'b1;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, op_on = 1'b0, ccm = 1'b1, below = 1'b1, f_in = 1'b0, f_ov = 1'b0;
  logic clr = 1'b0, ext_low = 1'b0, pin, oe, cwr, crd, unm, hiz, sink, con, sp, nota, swi, sin, alert, u;
  logic [7:0] code;
  logic [15:0] data, rdd, d;
  logic [11:0] dac;
  int fails = 0, checks_done = 0, n;
  logic [7:0] codes [9] = '{8'h41, 8'h45, 8'h56, 8'h63, 8'h64, 8'h65, 8'h66, 8'hdb, 8'hdc};
  logic [15:0] defs [9] = '{16'h00b8, 16'h00b8, 16'h0080, 16'h00b8, 16'h8000, 16'hd200, 16'hf258, 16'hfabc, 16'hfbe8};
  always #2 mclk_i = ~mclk_i;
  output_off_sequencer #(.TICK_DIV(DIV)) u_output_off_sequencer (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .enable_pin_i(pin), .enable_pin_o(), .enable_pin_oe_o(oe), .op_on_i(op_on), .ccm_mode_i(ccm),
    .vout_code_i(12'h800), .channel_config_word_i({7'h00, cfg}), .vout_below_eighth_i(below), .in_ov_fault_i(f_in),
    .out_ov_fault_i(f_ov), .out_uv_fault_i(1'b0), .ton_max_fault_i(1'b0), .clear_faults_i(clr), .cmd_wr_i(cwr),
    .cmd_rd_i(crd), .cmd_code_i(code), .cmd_data_i(data), .cmd_rd_data_o(rdd), .cmd_unmapped_o(unm),
    .dac_ref_o(dac), .gate_hiz_o(hiz), .sink_enable_o(sink), .channel_on_o(con), .start_pulse_o(sp),
    .toff_warn_o(), .status_byte_nota_o(nota), .status_word_input_o(swi), .status_input_in_ov_o(sin), .alert_o(alert));
  oos_host u_oos_host (.mclk_i(mclk_i), .enable_pin_oe_i(oe), .ext_low_i(ext_low), .enable_pin_o(pin),
    .cmd_rd_data_i(rdd), .cmd_unmapped_i(unm), .cmd_wr_o(cwr), .cmd_rd_o(crd), .cmd_code_o(code), .cmd_data_o(data));
  task automatic wrap_up;
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  // exact value compare
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // window compare
  task automatic chkr(input int c, input int lo, input int hi);
    checks_done++;
    if (c < lo || c > hi) begin
      fails++;
      $display("ERROR %0t count %0d not in %0d..%0d", $time, c, lo, hi);
    end
  endtask : chkr
  task automatic tk(input int k);
    repeat (k) @(posedge mclk_i) #1;
  endtask : tk
  // bounded wait; running out ends the run
  task automatic wait_for(input int s, input logic v, input int lim, output int c);
    c = 0;
    while ((s == 0 ? sp : (s == 1 ? hiz : oe)) !== v) begin
      tk(1);
      c++;
      if (c > lim) begin
        chkr(c, 0, lim);
        wrap_up();
      end
    end
  endtask : wait_for
  initial begin
    tk(16);
    rst_n_i = 1'b1;
    tk(4);
    for (int i = 0; i < 9; i++) begin
      u_oos_host.rd(codes[i], d, u);
      chk(d, defs[i]);
    end
    u_oos_host.rd(8'h00, d, u);
    chk({u, d[14:0]}, 16'h8000);
    u_oos_host.wr(8'h65, 16'h0000);
    u_oos_host.wr(8'hdc, 16'h0089);
    u_oos_host.wr(8'hdb, 16'h8000);
    u_oos_host.wr(8'h64, 16'h0001);
    u_oos_host.rd(8'h64, d, u);
    chk(d, 16'h0001);
    @(posedge mclk_i) #1 op_on = 1'b1;
    wait_for(0, 1'b1, 200, n);
    tk(4);
    {op_on, ccm} = 2'b00;
    // fault inside the off wait is ignored
    tk(50);
    f_ov = 1'b1;
    @(posedge mclk_i) #1 f_ov = 1'b0;
    tk(175);
    chk({15'h0000, sink}, 16'h0000);
    wait_for(1, 1'b1, 400, n);
    chkr(n + 226, 230, 275);
    @(posedge mclk_i) #1 f_in = 1'b1;
    @(posedge mclk_i) #1 f_in = 1'b0;
    chk({12'h000, nota, swi, sin, alert}, 16'h000f);
    @(posedge mclk_i) #1 clr = 1'b1;
    @(posedge mclk_i) #1 clr = 1'b0;
    chk({15'h0000, alert}, 16'h0000);
    @(posedge mclk_i) #1 {op_on, ccm} = 2'b11;
    wait_for(0, 1'b1, 200, n);
    tk(4);
    f_ov = 1'b1;
    @(posedge mclk_i) #1 f_ov = 1'b0;
    chk({15'h0000, hiz}, 16'h0001);
    wait_for(0, 1'b1, 30000, n);
    chkr(n, 23990, 24010);
    @(posedge mclk_i) #1 {ext_low, below, cfg} = 3'b100;
    tk(8);
    ext_low = 1'b0;
    wait_for(2, 1'b0, 30000, n);
    chkr(n + 4, 28790, 28810);
    tk(20);
    chk({15'h0000, con}, 16'h0000);
    below = 1'b1;
    wait_for(0, 1'b1, 100, n);
    chk({15'h0000, sp}, 16'h0001);
    wrap_up();
  end
endmodule : output_off_sequencer_tb
`default_nettype wire
